/* File: src/dvp_cfg.svh */
// Register offsets, field positions and reset values of the volume and power register slice.
// Included by the package and the design modules; definitions only.
`ifndef DVP_CFG_SVH
`define DVP_CFG_SVH
`define DVP_ADDR_W 8
`define DVP_DATA_W 8
`define DVP_OFS_ATT_CH14 8'h19
`define DVP_OFS_ATT_CH15 8'h1A
`define DVP_OFS_ATT_CH16 8'h1B
`define DVP_OFS_CM_DRIVE 8'h1C
`define DVP_OFS_PWR_CH1_TO_4 8'h1D
`define DVP_OFS_PWR_CH5_TO_8 8'h1E
`define DVP_OFS_PWR_CH9_TO_12 8'h1F
`define DVP_OFS_PWR_CH13_TO_16 8'h20
`define DVP_RST_ATT 8'h00
`define DVP_RST_CM_DRIVE 8'h02
`define DVP_RST_PWR 8'hAA
`define DVP_BIT_DRIVE 5
`define DVP_BIT_CM 1
`define DVP_CM_DRIVE_MASK 8'h22
`define DVP_ATT_MAX 8'hFF
`define DVP_NUM_ATT 3
`define DVP_NUM_PWR 4
`define DVP_NUM_CH 16
`endif

/* File: src/dvp_pkg.sv */
// Types shared by the volume and power register slice.
// Assumes dvp_cfg.svh for widths.
`include "dvp_cfg.svh"
package dvp_pkg;
  typedef enum logic [1:0] {
    DVP_PERF_LOW = 2'b00,
    DVP_PERF_LOWEST = 2'b01,
    DVP_PERF_BEST = 2'b10,
    DVP_PERF_GOOD = 2'b11
  } dvp_perf_t;
  typedef struct packed {
    logic [`DVP_ADDR_W-1:0] addr;
    logic [`DVP_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dvp_bus_t;
  typedef struct packed {
    logic drive_8ma;
    logic cm_5v;
  } dvp_analog_t;
endpackage

/* File: src/dvp_regfile.sv */
// Small register array holding the attenuation and power words.
// Assumes one writer port; read data come out of a register.
`timescale 1ns/1ps
`include "dvp_cfg.svh"
module dvp_regfile #(
  parameter int DEPTH = 7,
  parameter int AW = 3,
  parameter logic [DEPTH*8-1:0] RST_IMAGE = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [7:0] rd_data_ff,
  output logic [DEPTH*8-1:0] words
);
  logic [7:0] mem_ff [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_word
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          mem_ff[gi] <= RST_IMAGE[gi*8 +: 8];
        else if (ce && wr_en && wr_idx == AW'(gi))
          mem_ff[gi] <= wr_data;
      end
      assign words[gi*8 +: 8] = mem_ff[gi];
    end
  endgenerate

  // Write-through keeps a read in the same cycle as a write coherent
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_ff <= 8'h00;
    else if (ce)
      rd_data_ff <= (wr_en && wr_idx == rd_idx) ? wr_data : mem_ff[rd_idx];
  end
endmodule // dvp_regfile

/* File: src/dvp_regs.sv */
// Volume, pad drive, common-mode and per-channel power register slice.
// Assumes a same-clock register master: one-cycle strobes, read data in the next cycle.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "dvp_cfg.svh"
module dvp_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire dvp_pkg::dvp_bus_t bus,
  output logic [7:0] rd_data_ff,
  output logic [7:0] attenuation_ch14,
  output logic [7:0] attenuation_ch15,
  output logic [7:0] attenuation_ch16,
  output dvp_pkg::dvp_analog_t analog_ff,
  output dvp_pkg::dvp_perf_t [`DVP_NUM_CH-1:0] perf_level
);
  localparam int NWORD = `DVP_NUM_ATT + `DVP_NUM_PWR;
  localparam int IW = 3;
  localparam logic [NWORD*8-1:0] RST_IMAGE = {{`DVP_NUM_PWR{`DVP_RST_PWR}}, {`DVP_NUM_ATT{`DVP_RST_ATT}}};

  // Word index in the array, or not-an-array-word
  function automatic logic [IW:0] word_index(input logic [7:0] a);
    logic [IW:0] r;
    r = {1'b1, 3'h0};
    unique case (a)
      `DVP_OFS_ATT_CH14: r = 4'h0;
      `DVP_OFS_ATT_CH15: r = 4'h1;
      `DVP_OFS_ATT_CH16: r = 4'h2;
      `DVP_OFS_PWR_CH1_TO_4: r = 4'h3;
      `DVP_OFS_PWR_CH5_TO_8: r = 4'h4;
      `DVP_OFS_PWR_CH9_TO_12: r = 4'h5;
      `DVP_OFS_PWR_CH13_TO_16: r = 4'h6;
      default: r = {1'b1, 3'h0};
    endcase
    return r;
  endfunction

  logic [IW:0] wr_sel;
  logic [IW:0] rd_sel;
  logic [NWORD*8-1:0] words;
  logic [7:0] cm_word;
  logic [7:0] nxt_rd_data;

  assign wr_sel = word_index(bus.addr);
  assign rd_sel = word_index(bus.addr);

  dvp_regfile #(
    .DEPTH(NWORD),
    .AW(IW),
    .RST_IMAGE(RST_IMAGE)
  ) u_words (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr_en(bus.wr && !wr_sel[IW]),
    .wr_idx(wr_sel[IW-1:0]),
    .wr_data(bus.wdata),
    .rd_idx(rd_sel[IW-1:0]),
    .rd_data_ff(),
    .words(words)
  );

  // Only the two defined bits are stored, so the rest read zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      analog_ff.drive_8ma <= 1'(`DVP_RST_CM_DRIVE >> `DVP_BIT_DRIVE);
      analog_ff.cm_5v <= 1'(`DVP_RST_CM_DRIVE >> `DVP_BIT_CM);
    end
    else if (ce && bus.wr && bus.addr == `DVP_OFS_CM_DRIVE)
    begin
      analog_ff.drive_8ma <= bus.wdata[`DVP_BIT_DRIVE];
      analog_ff.cm_5v <= bus.wdata[`DVP_BIT_CM];
    end
  end

  always_comb
  begin
    cm_word = 8'h00;
    cm_word[`DVP_BIT_DRIVE] = analog_ff.drive_8ma;
    cm_word[`DVP_BIT_CM] = analog_ff.cm_5v;
  end

  // All read paths meet before the flop, so the read port leaves straight from a register
  always_comb
  begin
    nxt_rd_data = 8'h00;
    if (bus.addr == `DVP_OFS_CM_DRIVE)
      nxt_rd_data = (bus.wr) ? (bus.wdata & `DVP_CM_DRIVE_MASK) : cm_word;
    else if (!rd_sel[IW])
      nxt_rd_data = (bus.wr) ? bus.wdata : words[rd_sel[IW-1:0]*8 +: 8];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_ff <= 8'h00;
    else if (ce)
      rd_data_ff <= bus.rd ? nxt_rd_data : 8'h00;
  end

  // Attenuation codes leave as written; the datapath maps one step to 0.375 dB
  always_comb
  begin
    attenuation_ch14 = words[0 +: 8];
    attenuation_ch15 = words[8 +: 8];
    attenuation_ch16 = words[16 +: 8];
  end

  genvar gc;
  generate
    for (gc = 0; gc < `DVP_NUM_CH; gc++)
    begin : g_perf
      assign perf_level[gc] = dvp_pkg::dvp_perf_t'(words[`DVP_NUM_ATT*8 + gc*2 +: 2]);
    end
  endgenerate

  volume_max_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && bus.wr && bus.addr == `DVP_OFS_ATT_CH16 && bus.wdata == `DVP_ATT_MAX
    |=> attenuation_ch16 == `DVP_ATT_MAX) else $error("ch16 full attenuation not held");
  vol_write_back_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && bus.wr && bus.addr == `DVP_OFS_ATT_CH14 ##1 ce && bus.rd && bus.addr == `DVP_OFS_ATT_CH14 && !bus.wr
    |=> rd_data_ff == $past(bus.wdata, 2)) else $error("ch14 readback mismatch");
  drive_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && bus.wr && bus.addr == `DVP_OFS_CM_DRIVE |=> analog_ff.drive_8ma == $past(bus.wdata[5]))
    else $error("drive bit wrong");
  cm_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && bus.wr && bus.addr == `DVP_OFS_CM_DRIVE |=> analog_ff.cm_5v == $past(bus.wdata[1]))
    else $error("common-mode bit wrong");
  cm_read_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && bus.rd && bus.addr == `DVP_OFS_CM_DRIVE |=> (rd_data_ff & ~`DVP_CM_DRIVE_MASK) == 8'h00)
    else $error("unused common-mode bits not zero");
  perf_low_field_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && bus.wr && bus.addr == `DVP_OFS_PWR_CH13_TO_16
    |=> perf_level[12] == dvp_pkg::dvp_perf_t'($past(bus.wdata[1:0])))
    else $error("ch13 field misplaced");
  perf_top_field_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && bus.wr && bus.addr == `DVP_OFS_PWR_CH1_TO_4
    |=> perf_level[3] == dvp_pkg::dvp_perf_t'($past(bus.wdata[7:6])))
    else $error("ch4 field misplaced");
  freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(perf_level) && $stable(analog_ff) && $stable(attenuation_ch15))
    else $error("state moved while frozen");
  unmapped_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && bus.rd && !bus.wr && bus.addr > `DVP_OFS_PWR_CH13_TO_16 |=> rd_data_ff == 8'h00)
    else $error("unmapped read not zero");
  best_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && bus.wr && bus.addr == `DVP_OFS_PWR_CH5_TO_8 && bus.wdata == `DVP_RST_PWR
    |=> perf_level[4] == dvp_pkg::DVP_PERF_BEST && perf_level[7] == dvp_pkg::DVP_PERF_BEST)
    else $error("best code decode wrong");
endmodule // dvp_regs

/* File: tb/dvp_regs_tb.sv */
// Self-checking bench for the volume, pad drive, common-mode and power register slice.
// Assumes dvp_pkg compiled first; the bench drives the register port itself, no partner model.
`timescale 1ns/1ps
module dvp_regs_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b0;
  dvp_pkg::dvp_bus_t bus = '0;
  logic [7:0] rd_data_ff;
  logic [7:0] attenuation_ch14;
  logic [7:0] attenuation_ch15;
  logic [7:0] attenuation_ch16;
  dvp_pkg::dvp_analog_t analog_ff;
  dvp_pkg::dvp_perf_t [15:0] perf_level;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] rst_img [8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'hAA, 8'hAA, 8'hAA, 8'hAA};
  logic [7:0] vol [3] = '{8'hFF, 8'h01, 8'h80};
  logic [7:0] cm_in [4] = '{8'hFF, 8'h00, 8'h20, 8'h02};
  logic [7:0] pwr_pat [4] = '{8'hE4, 8'h1B, 8'h4E, 8'hB1};
  dvp_pkg::dvp_perf_t codes [4] = '{dvp_pkg::DVP_PERF_LOW, dvp_pkg::DVP_PERF_LOWEST,
    dvp_pkg::DVP_PERF_BEST, dvp_pkg::DVP_PERF_GOOD};
  always #4 clk = ~clk;
  dvp_regs u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .bus(bus), .rd_data_ff(rd_data_ff),
    .attenuation_ch14(attenuation_ch14), .attenuation_ch15(attenuation_ch15),
    .attenuation_ch16(attenuation_ch16), .analog_ff(analog_ff), .perf_level(perf_level));
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // A write leaves the strobe up; the next call replaces it on the following edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= {a, d, 2'b10};
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= {a, 8'h00, 2'b01};
    @(posedge clk);
    bus <= '0;
    #1 chk(rd_data_ff, e);
  endtask
  task automatic defaults();
    for (int i = 0; i < 8; i++)
      rdc(8'h19 + 8'(i), rst_img[i]);
    chk(attenuation_ch14 | attenuation_ch15 | attenuation_ch16, 8'h00);
    chk({6'h00, analog_ff}, 8'h01);
    for (int k = 0; k < 4; k++)
      chk(perf_level[4*k +: 4], 8'hAA);
    $display("test reset_values done");
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    ce <= 1'b1;
    defaults();
    for (int i = 0; i < 3; i++)
      wr(8'h19 + 8'(i), vol[i]);
    for (int i = 0; i < 3; i++)
      rdc(8'h19 + 8'(i), vol[i]);
    chk(attenuation_ch14, 8'hFF);
    chk(attenuation_ch15, 8'h01);
    chk(attenuation_ch16, 8'h80);
    $display("test volume done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h1C, cm_in[i]);
      rdc(8'h1C, cm_in[i] & 8'h22);
      chk({6'h00, analog_ff}, {6'h00, cm_in[i][5], cm_in[i][1]});
    end
    $display("test common_mode_drive done");
    for (int k = 0; k < 4; k++)
      wr(8'h1D + 8'(k), pwr_pat[k]);
    for (int k = 0; k < 4; k++)
    begin
      rdc(8'h1D + 8'(k), pwr_pat[k]);
      chk(perf_level[4*k +: 4], pwr_pat[k]);
    end
    for (int j = 0; j < 4; j++)
      chk(8'(perf_level[j]), 8'(codes[j]));
    $display("test power_fields done");
    wr(8'h18, 8'h5A);
    rdc(8'h18, 8'h00);
    wr(8'h21, 8'h5A);
    rdc(8'h21, 8'h00);
    // Strobes seen while the clock enable is low must leave the bank untouched
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h19, 8'h33);
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    ce <= 1'b1;
    rdc(8'h19, 8'hFF);
    chk(attenuation_ch16, 8'h80);
    $display("test unmapped_and_hold done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    defaults();
    conclude();
  end
endmodule // dvp_regs_tb
